// file: src/csbu_pkg.sv
/*
 * csbu_pkg: shared types and constants for the compare, skip and
 * branch unit. Assumes a core with an 8-bit status register whose
 * bit order is I T H S V N Z C, MSB first.
 */
package csbu_pkg;

    localparam int CSBU_PC_W = 16;
    localparam int CSBU_OFS_W = 7;
    localparam logic [CSBU_PC_W-1:0] CSBU_PC_RST = 16'h0000;
    localparam logic [7:0] CSBU_FLAGS_RST = 8'h00;
    localparam logic [CSBU_PC_W-1:0] CSBU_STEP = 16'h0001;
    localparam logic [CSBU_PC_W-1:0] CSBU_SKIP_SHORT = 16'h0002;
    localparam logic [CSBU_PC_W-1:0] CSBU_SKIP_LONG = 16'h0003;
    // flag positions inside the status byte
    localparam logic [2:0] CSBU_FLAG_C = 3'h0;
    localparam logic [2:0] CSBU_FLAG_Z = 3'h1;
    localparam logic [2:0] CSBU_FLAG_N = 3'h2;
    localparam logic [2:0] CSBU_FLAG_V = 3'h3;
    localparam logic [2:0] CSBU_FLAG_H = 3'h5;

    typedef enum logic [4:0] {
        CSBU_NOP = 5'h00,
        compare_op = 5'h01,
        compare_with_carry_op = 5'h02,
        compare_immediate_op = 5'h03,
        skip_reg_bit_clear_op = 5'h04,
        skip_reg_bit_set_op = 5'h05,
        skip_io_bit_clear_op = 5'h06,
        skip_io_bit_set_op = 5'h07,
        branch_flag_set_op = 5'h08,
        branch_flag_clear_op = 5'h09,
        branch_equal_op = 5'h0a,
        branch_not_equal_op = 5'h0b,
        branch_carry_set_op = 5'h0c,
        branch_carry_clear_op = 5'h0d,
        branch_same_higher_op = 5'h0e,
        branch_minus_op = 5'h0f,
        branch_plus_op = 5'h10,
        branch_signed_ge_op = 5'h11,
        branch_signed_lt_op = 5'h12,
        branch_half_carry_set_op = 5'h13
    } csbu_op_t;

    typedef struct packed {
        logic i;
        logic t;
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } csbu_flags_t;

    typedef struct packed {
        csbu_op_t op;
        logic [7:0] rd;
        logic [7:0] rr;
        logic [7:0] imm;
        logic [2:0] bit_sel;
        logic [7:0] io_val;
        logic [2:0] flag_sel;
        logic [CSBU_OFS_W-1:0] offset;
        logic [CSBU_PC_W-1:0] pc;
        logic next_two_word;
    } csbu_req_t;

    function automatic logic csbu_is_cmp(input csbu_op_t op);
        return op inside {compare_op, compare_with_carry_op, compare_immediate_op};
    endfunction : csbu_is_cmp

    function automatic logic csbu_is_skip(input csbu_op_t op);
        return op inside {skip_reg_bit_clear_op, skip_reg_bit_set_op,
                          skip_io_bit_clear_op, skip_io_bit_set_op};
    endfunction : csbu_is_skip

    function automatic logic csbu_is_branch(input csbu_op_t op);
        return (op >= branch_flag_set_op) && (op <= branch_half_carry_set_op);
    endfunction : csbu_is_branch

endpackage : csbu_pkg

// file: src/csbu_cmp.sv
/*
 * csbu_cmp: 8-bit subtractor for the compare instructions, giving the
 * arithmetic flags only. Purely combinational; the caller registers.
 */
`timescale 1ns/10ps
`default_nettype none

module csbu_cmp (
    // operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    // flags of a - b - cin
    output logic c,
    output logic zero,
    output logic n,
    output logic v,
    output logic h
);
    wire logic [8:0] diff;
    wire logic [7:0] r;

    assign diff = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    assign r = diff[7:0];
    // borrow out of bit 7 shows as bit 8 of the wide difference
    assign c = diff[8];
    assign zero = (r == 8'h00);
    assign n = r[7];
    assign v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    assign h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);

endmodule : csbu_cmp
`default_nettype wire

// file: src/csbu_top.sv
/*
 * csbu_top: executes compare, conditional skip and conditional
 * relative branch instructions for an 8-bit core. One request per
 * cycle; the answer is registered one cycle later.
 * Assumes the decoder presents operands, the current program counter
 * and status byte with req_valid, and that the length of the following
 * instruction is known as next_two_word.
 */
// Notes on behaviour
// - compare subtracts registers, keeps flags only
// - compare with carry also subtracts carry
// - compare immediate subtracts constant, no write
// - compares update Z, N, V, C, H
// - register bit clear skips next instruction
// - register bit set skips next instruction
// - io bit clear skips next instruction
// - io bit set skips next instruction
// - selected flag set branches to pc+k+1
// - selected flag clear branches to pc+k+1
// - equal branch taken when Z is one
// - not equal branch taken when Z zero
// - carry set branch taken when C one
// - carry clear, same-higher taken when C zero
// - minus branch taken when N one
// - plus branch taken when N zero
// - signed greater-or-equal branch provided
// - signed less-than branch provided
// - half carry set branch provided
// - skips and branches leave flags alone
`timescale 1ns/10ps
`default_nettype none

module csbu_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // request from the decoder
    input wire logic req_valid,
    input wire csbu_pkg::csbu_req_t req,
    input wire csbu_pkg::csbu_flags_t cur_flags,
    // program counter update
    output logic done_q,
    output logic pc_load_q,
    output logic [csbu_pkg::CSBU_PC_W-1:0] pc_next_q,
    output logic taken_q,
    // status flag update
    output logic flags_we_q,
    output csbu_pkg::csbu_flags_t flags_q
);
    import csbu_pkg::*;

    // chosen-flag test shared by every branch form
    function automatic logic branch_cond(input csbu_op_t op,
                                         input csbu_flags_t f,
                                         input logic [2:0] sel);
        logic [7:0] fv;
        logic cond;
        fv = f;
        cond = 1'b0;
        case (op)
            branch_flag_set_op: cond = fv[sel];
            branch_flag_clear_op: cond = ~fv[sel];
            branch_equal_op: cond = fv[CSBU_FLAG_Z];
            branch_not_equal_op: cond = ~fv[CSBU_FLAG_Z];
            branch_carry_set_op: cond = fv[CSBU_FLAG_C];
            branch_carry_clear_op,
            branch_same_higher_op: cond = ~fv[CSBU_FLAG_C];
            branch_minus_op: cond = fv[CSBU_FLAG_N];
            branch_plus_op: cond = ~fv[CSBU_FLAG_N];
            // stored S may be stale, so form N xor V afresh
            branch_signed_ge_op:
                cond = ~(fv[CSBU_FLAG_N] ^ fv[CSBU_FLAG_V]);
            branch_signed_lt_op:
                cond = fv[CSBU_FLAG_N] ^ fv[CSBU_FLAG_V];
            branch_half_carry_set_op: cond = fv[CSBU_FLAG_H];
            default: cond = 1'b0;
        endcase
        return cond;
    endfunction : branch_cond

    // operation class
    wire logic is_cmp;
    wire logic is_skip;
    wire logic is_branch;
    wire logic is_cpc;
    wire logic is_cpi;

    assign is_cmp = csbu_is_cmp(req.op);
    assign is_skip = csbu_is_skip(req.op);
    assign is_branch = csbu_is_branch(req.op);
    assign is_cpc = (req.op == compare_with_carry_op);
    assign is_cpi = (req.op == compare_immediate_op);

    // compare datapath
    wire logic [7:0] sub_b;
    wire logic sub_cin;
    wire logic sub_c;
    wire logic sub_zero;
    wire logic sub_n;
    wire logic sub_v;
    wire logic sub_h;
    wire logic new_z;
    wire csbu_flags_t cmp_flags;

    assign sub_b = is_cpi ? req.imm : req.rr;
    assign sub_cin = is_cpc ? cur_flags.c : 1'b0;

    csbu_cmp u_cmp (
        .a(req.rd),
        .b(sub_b),
        .cin(sub_cin),
        .c(sub_c),
        .zero(sub_zero),
        .n(sub_n),
        .v(sub_v),
        .h(sub_h)
    );

    // chained compares keep Z only if the lower byte was equal too
    assign new_z = sub_zero & (is_cpc ? cur_flags.z : 1'b1);

    // difference is dropped; only five flags change, I T S pass through
    assign cmp_flags = '{i: cur_flags.i, t: cur_flags.t, h: sub_h,
                         s: cur_flags.s, v: sub_v, n: sub_n,
                         z: new_z, c: sub_c};

    // skip and branch conditions
    wire logic reg_bit;
    wire logic io_bit;
    wire logic skip_cond;
    wire logic br_cond;
    wire logic cond_true;

    assign reg_bit = req.rr[req.bit_sel];
    assign io_bit = req.io_val[req.bit_sel];
    assign skip_cond =
        (req.op == skip_reg_bit_clear_op) ? ~reg_bit :
        (req.op == skip_reg_bit_set_op) ? reg_bit :
        (req.op == skip_io_bit_clear_op) ? ~io_bit :
        (req.op == skip_io_bit_set_op) ? io_bit :
        1'b0;
    assign br_cond = branch_cond(req.op, cur_flags, req.flag_sel);
    assign cond_true = (is_skip & skip_cond) | (is_branch & br_cond);

    // next program counter
    wire logic [CSBU_PC_W-1:0] ofs_ext;
    wire logic [CSBU_PC_W-1:0] pc_seq;
    wire logic [CSBU_PC_W-1:0] pc_skip;
    wire logic [CSBU_PC_W-1:0] pc_branch;
    wire logic [CSBU_PC_W-1:0] pc_d;

    // offset is two's complement words, so it reaches back as well
    assign ofs_ext = {{(CSBU_PC_W-CSBU_OFS_W){req.offset[CSBU_OFS_W-1]}},
                      req.offset};
    assign pc_seq = req.pc + CSBU_STEP;
    // a skipped two-word instruction needs the longer step
    assign pc_skip = req.pc + (req.next_two_word ? CSBU_SKIP_LONG
                                                 : CSBU_SKIP_SHORT);
    assign pc_branch = req.pc + ofs_ext + CSBU_STEP;
    assign pc_d = !cond_true ? pc_seq :
                  is_skip ? pc_skip : pc_branch;

    // flag write only for compares
    wire logic flags_we_d;

    assign flags_we_d = req_valid & is_cmp;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            done_q <= 1'b0;
            pc_load_q <= 1'b0;
            pc_next_q <= CSBU_PC_RST;
            taken_q <= 1'b0;
            flags_we_q <= 1'b0;
            flags_q <= CSBU_FLAGS_RST;
        end else begin
            done_q <= req_valid;
            pc_load_q <= req_valid;
            taken_q <= req_valid & cond_true;
            flags_we_q <= flags_we_d;
            if (req_valid) begin
                pc_next_q <= pc_d;
            end
            if (flags_we_d) begin
                flags_q <= cmp_flags;
            end
        end
    end

    // selected status bit, seen by the flag-select check
    wire logic [7:0] cur_bits;
    wire logic sel_bit;

    assign cur_bits = cur_flags;
    assign sel_bit = cur_bits[req.flag_sel];

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    a_cmp_flags_only: assert property (
        req_valid && is_cmp |=> flags_we_q && !taken_q
            && pc_next_q == $past(req.pc) + CSBU_STEP)
        else $error("compare must only step pc and write flags");

    a_cmp_equal_zero: assert property (
        req_valid && req.op == compare_op |=>
            flags_q.z == ($past(req.rd) == $past(req.rr))
            && flags_q.c == ($past(req.rd) < $past(req.rr)))
        else $error("compare flags wrong");

    a_cpc_borrow: assert property (
        req_valid && is_cpc |=>
            flags_q.c == ({1'b0, $past(req.rd)} <
                          {1'b0, $past(req.rr)} + {8'h00, $past(cur_flags.c)}))
        else $error("compare with carry borrow wrong");

    a_cpi_immediate: assert property (
        req_valid && is_cpi |=>
            flags_q.c == ($past(req.rd) < $past(req.imm))
            && flags_q.n == ($past(req.rd) - $past(req.imm)) >> 7)
        else $error("compare immediate flags wrong");

    a_cmp_keep_other: assert property (
        req_valid && is_cmp |=> flags_q.i == $past(cur_flags.i)
            && flags_q.t == $past(cur_flags.t)
            && flags_q.s == $past(cur_flags.s))
        else $error("compare touched a flag it must not");

    a_skip_target: assert property (
        req_valid && is_skip && skip_cond |=> taken_q
            && pc_next_q == $past(req.pc) + ($past(req.next_two_word)
                ? CSBU_SKIP_LONG : CSBU_SKIP_SHORT))
        else $error("skip target wrong");

    a_branch_target: assert property (
        req_valid && is_branch && br_cond |=> taken_q
            && pc_next_q == $past(req.pc) + $past(ofs_ext) + CSBU_STEP)
        else $error("branch target wrong");

    a_equal_on_z: assert property (
        req_valid && req.op inside {branch_equal_op, branch_not_equal_op} |=>
            taken_q == ($past(cur_flags.z) == ($past(req.op) == branch_equal_op)))
        else $error("equal branch ignores zero flag");

    a_carry_minus: assert property (
        req_valid && req.op inside {branch_carry_set_op, branch_carry_clear_op,
            branch_same_higher_op, branch_minus_op, branch_plus_op} |=>
            taken_q == (($past(req.op) == branch_minus_op) ? $past(cur_flags.n)
                : ($past(req.op) == branch_plus_op) ? !$past(cur_flags.n)
                : ($past(req.op) == branch_carry_set_op) ? $past(cur_flags.c)
                : !$past(cur_flags.c)))
        else $error("carry or sign branch condition wrong");

    a_signed_xor: assert property (
        req_valid && req.op inside {branch_signed_ge_op, branch_signed_lt_op} |=>
            taken_q == ($past(cur_flags.n) ^ $past(cur_flags.v)
                ^ ($past(req.op) == branch_signed_ge_op)))
        else $error("signed branch condition wrong");

    a_flags_untouched: assert property (
        req_valid && (is_skip || is_branch) |=> !flags_we_q && $stable(flags_q))
        else $error("skip or branch wrote flags");

    a_false_steps: assert property (
        req_valid && !cond_true |=> !taken_q && pc_load_q
            && pc_next_q == $past(req.pc) + CSBU_STEP)
        else $error("false condition did not step pc");

    a_flag_sel_branch: assert property (
        req_valid && req.op inside {branch_flag_set_op, branch_flag_clear_op} |=>
            taken_q == ($past(sel_bit) == ($past(req.op) == branch_flag_set_op)))
        else $error("flag select branch condition wrong");

    a_half_branch: assert property (
        req_valid && req.op == branch_half_carry_set_op |=>
            taken_q == $past(cur_flags.h))
        else $error("half carry branch condition wrong");

    a_skip_reg_bit: assert property (
        req_valid && req.op inside {skip_reg_bit_clear_op, skip_reg_bit_set_op} |=>
            taken_q == ($past(req.rr[req.bit_sel])
                == ($past(req.op) == skip_reg_bit_set_op)))
        else $error("register bit skip condition wrong");

    a_skip_io_bit: assert property (
        req_valid && req.op inside {skip_io_bit_clear_op, skip_io_bit_set_op} |=>
            taken_q == ($past(req.io_val[req.bit_sel])
                == ($past(req.op) == skip_io_bit_set_op)))
        else $error("io bit skip condition wrong");

    a_cmp_half_ovf: assert property (
        req_valid && req.op == compare_op |=>
            flags_q.h == ($past(req.rd[3:0]) < $past(req.rr[3:0]))
            && flags_q.v == (($past(req.rd[7]) != $past(req.rr[7]))
                && (flags_q.n != $past(req.rd[7]))))
        else $error("compare half carry or overflow wrong");

    a_cpc_zero_chain: assert property (
        req_valid && is_cpc && !cur_flags.z |=> !flags_q.z)
        else $error("compare with carry set zero after unequal byte");

    a_cpc_equal_carry: assert property (
        req_valid && is_cpc && req.rd == req.rr |=>
            flags_q.c == $past(cur_flags.c))
        else $error("compare with carry ignored the carry in");

    a_cpi_no_rr: assert property (
        req_valid && is_cpi |=>
            flags_q.z == ($past(req.rd) == $past(req.imm)))
        else $error("compare immediate used the wrong operand");

    a_cmp_negative: assert property (
        req_valid && req.op == compare_op |=>
            flags_q.n == (8'($past(req.rd) - $past(req.rr)) >= 8'h80))
        else $error("compare negative flag wrong");

    a_answer_pulse: assert property (
        req_valid |=> done_q && pc_load_q)
        else $error("request not answered");

    // pulses last one cycle; held outputs keep their last answer
    a_idle_quiet: assert property (
        !req_valid |=> !done_q && !pc_load_q && !taken_q && !flags_we_q
            && $stable(pc_next_q) && $stable(flags_q))
        else $error("outputs moved without a request");

    a_step_no_taken: assert property (
        req_valid && !is_skip && !is_branch |=> !taken_q)
        else $error("non-branch request reported taken");

    c_cmp_then_branch: cover property (
        req_valid && is_cmp ##1 req_valid && is_branch && br_cond);
    c_skip_long: cover property (
        req_valid && is_skip && skip_cond && req.next_two_word);
    c_branch_back: cover property (
        req_valid && is_branch && br_cond && req.offset[CSBU_OFS_W-1]);
    c_cpc_chain: cover property (
        req_valid && is_cpc && cur_flags.z && sub_zero);
    c_io_skip_clear: cover property (
        req_valid && req.op == skip_io_bit_clear_op && skip_cond);

endmodule : csbu_top
`default_nettype wire

// file: dv/csbu_core_model.sv
/* csbu_core_model: program counter and status byte of the core around the unit.
   assumes the bench may preload the status byte between instructions. */
`timescale 1ns/10ps
`default_nettype none
module csbu_core_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // results from the unit
    input wire logic pc_load,
    input wire logic [csbu_pkg::CSBU_PC_W-1:0] pc_in,
    input wire logic flags_we,
    input wire csbu_pkg::csbu_flags_t flags_in,
    // preload from the bench
    input wire logic preset_en,
    input wire csbu_pkg::csbu_flags_t preset_val,
    // state seen by the decoder
    output logic [csbu_pkg::CSBU_PC_W-1:0] pc_q,
    output csbu_pkg::csbu_flags_t status_q
);
    import csbu_pkg::*;
    // preload wins so a scenario can force any flag pattern
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pc_q <= CSBU_PC_RST;
            status_q <= CSBU_FLAGS_RST;
        end else begin
            if (preset_en) begin
                status_q <= preset_val;
            end else if (flags_we) begin
                status_q <= flags_in;
            end
            if (pc_load) begin
                pc_q <= pc_in;
            end
        end
    end
endmodule : csbu_core_model
`default_nettype wire

// file: dv/tb_top.sv
/* tb_top: self-checking bench for csbu_top beside the core model.
   assumes at most one request every other cycle unless a scenario means back to back. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import csbu_pkg::*;
    logic sys_clk;
    logic nrst;
    logic req_valid;
    logic preset_en;
    logic done_q;
    logic pc_load_q;
    logic taken_q;
    logic flags_we_q;
    logic [CSBU_PC_W-1:0] pc_next_q;
    logic [CSBU_PC_W-1:0] core_pc;
    csbu_req_t req;
    csbu_flags_t cur_flags;
    csbu_flags_t flags_q;
    csbu_flags_t preset_val;
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;

    csbu_top dut (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req(req),
        .cur_flags(cur_flags), .done_q(done_q), .pc_load_q(pc_load_q),
        .pc_next_q(pc_next_q), .taken_q(taken_q), .flags_we_q(flags_we_q), .flags_q(flags_q));
    csbu_core_model core (.sys_clk(sys_clk), .nrst(nrst), .pc_load(pc_load_q),
        .pc_in(pc_next_q), .flags_we(flags_we_q), .flags_in(flags_q), .preset_en(preset_en),
        .preset_val(preset_val), .pc_q(core_pc), .status_q(cur_flags));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic set_flags(input logic [7:0] f);
        @(posedge sys_clk);
        preset_en <= 1'b1;
        preset_val <= f;
        @(posedge sys_clk);
        preset_en <= 1'b0;
    endtask : set_flags

    // result is registered at the edge that samples the request
    task automatic go(input csbu_req_t q);
        @(posedge sys_clk);
        req <= q;
        req_valid <= 1'b1;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        #1;
    endtask : go

    function automatic logic [7:0] ref_cmp(input csbu_op_t op, input logic [7:0] a,
        input logic [7:0] b, input logic [7:0] f);
        logic ci;
        logic [8:0] r;
        logic [4:0] hr;
        logic [7:0] o;
        ci = (op == compare_with_carry_op) ? f[CSBU_FLAG_C] : 1'b0;
        r = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        hr = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
        o = f;
        o[CSBU_FLAG_C] = r[8];
        o[CSBU_FLAG_H] = hr[4];
        o[CSBU_FLAG_N] = r[7];
        o[CSBU_FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        o[CSBU_FLAG_Z] = (r[7:0] == 8'h00) && (op != compare_with_carry_op || f[CSBU_FLAG_Z]);
        return o;
    endfunction : ref_cmp

    function automatic logic br_cond(input csbu_op_t op, input logic [7:0] f,
        input logic [2:0] s);
        case (op)
            branch_flag_set_op: return f[s];
            branch_flag_clear_op: return !f[s];
            branch_equal_op: return f[CSBU_FLAG_Z];
            branch_not_equal_op: return !f[CSBU_FLAG_Z];
            branch_carry_set_op: return f[CSBU_FLAG_C];
            branch_minus_op: return f[CSBU_FLAG_N];
            branch_plus_op: return !f[CSBU_FLAG_N];
            branch_signed_ge_op: return !(f[CSBU_FLAG_N] ^ f[CSBU_FLAG_V]);
            branch_signed_lt_op: return f[CSBU_FLAG_N] ^ f[CSBU_FLAG_V];
            branch_half_carry_set_op: return f[CSBU_FLAG_H];
            default: return !f[CSBU_FLAG_C];
        endcase
    endfunction : br_cond

    task automatic test_compare();
        logic [7:0] av [6] = '{8'h05, 8'h00, 8'h80, 8'h7f, 8'h10, 8'h3c};
        logic [7:0] bv [6] = '{8'h05, 8'h01, 8'h01, 8'hff, 8'h01, 8'h3c};
        csbu_req_t r;
        logic [7:0] f;
        for (int k = 0; k < 6; k++) begin
            for (int o = 1; o <= 3; o++) begin
                for (int fi = 0; fi < 2; fi++) begin
                    f = fi ? 8'hff : 8'h00;
                    r = '0;
                    r.op = csbu_op_t'(o);
                    r.rd = av[k];
                    r.rr = (r.op == compare_immediate_op) ? ~bv[k] : bv[k];
                    r.imm = (r.op == compare_immediate_op) ? bv[k] : ~bv[k];
                    r.pc = 16'h0100;
                    set_flags(f);
                    go(r);
                    check(flags_we_q, 1'b1);
                    check(flags_q, ref_cmp(r.op, av[k], bv[k], f));
                    check(pc_next_q, 16'h0101);
                end
            end
        end
    endtask : test_compare

    task automatic test_skip();
        csbu_req_t r;
        logic [7:0] val;
        logic [CSBU_PC_W-1:0] ep;
        logic sk;
        for (int o = 4; o <= 7; o++) begin
            for (int v = 0; v < 2; v++) begin
                for (int t = 0; t < 2; t++) begin
                    r = '0;
                    r.op = csbu_op_t'(o);
                    r.bit_sel = 3'(o + v);
                    val = v ? (8'h01 << r.bit_sel) : ~(8'h01 << r.bit_sel);
                    // the other source holds the opposite bit to catch a swapped operand
                    r.rr = (o < 6) ? val : ~val;
                    r.io_val = (o < 6) ? ~val : val;
                    r.next_two_word = t[0];
                    r.pc = 16'hfffd;
                    sk = (v[0] == o[0]);
                    ep = r.pc + (sk ? (t ? CSBU_SKIP_LONG : CSBU_SKIP_SHORT) : CSBU_STEP);
                    go(r);
                    check(taken_q, sk);
                    check(pc_next_q, ep);
                    check(flags_we_q, 1'b0);
                end
            end
        end
    endtask : test_skip

    task automatic test_branch();
        csbu_req_t r;
        logic [CSBU_PC_W-1:0] ep;
        logic t;
        for (int o = 8; o <= 19; o++) begin
            for (int fi = 0; fi < 256; fi += 5) begin
                r = '0;
                r.op = csbu_op_t'(o);
                r.flag_sel = fi[5:3];
                r.offset = (fi % 3 == 0) ? 7'h40 : ((fi % 3 == 1) ? 7'h3f : 7'h7e);
                r.pc = 16'h0040;
                t = br_cond(r.op, fi[7:0], r.flag_sel);
                ep = r.pc + (t ? {{9{r.offset[6]}}, r.offset} + 16'h0001 : CSBU_STEP);
                set_flags(fi[7:0]);
                go(r);
                check(taken_q, t);
                check(pc_next_q, ep);
                check(flags_we_q, 1'b0);
            end
        end
    endtask : test_branch

    task automatic test_b2b();
        csbu_req_t a;
        csbu_req_t b;
        a = '0;
        a.op = skip_reg_bit_set_op;
        a.rr = 8'h80;
        a.bit_sel = 3'h7;
        a.next_two_word = 1'b1;
        a.pc = 16'h0200;
        b = '0;
        b.op = CSBU_NOP;
        b.pc = 16'h0205;
        @(posedge sys_clk);
        req <= a;
        req_valid <= 1'b1;
        @(posedge sys_clk);
        req <= b;
        #1;
        check(pc_next_q, 16'h0203);
        check(taken_q, 1'b1);
        check(pc_load_q, 1'b1);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        #1;
        check(done_q, 1'b1);
        check(taken_q, 1'b0);
        check(pc_next_q, 16'h0206);
        @(posedge sys_clk);
        #1;
        check(done_q, 1'b0);
        check(pc_load_q, 1'b0);
        check(core_pc, 16'h0206);
    endtask : test_b2b

    task automatic test_reset();
        csbu_req_t r;
        r = '0;
        r.op = compare_op;
        r.rr = 8'h01;
        r.pc = 16'h0010;
        go(r);
        @(posedge sys_clk);
        nrst <= 1'b0;
        #1;
        check(flags_q, CSBU_FLAGS_RST);
        check(pc_next_q, CSBU_PC_RST);
        @(posedge sys_clk);
        nrst <= 1'b1;
        // status byte was cleared with the core, so carry reads zero
        r.op = branch_carry_set_op;
        r.offset = 7'h05;
        go(r);
        check(pc_next_q, 16'h0011);
        check(taken_q, 1'b0);
    endtask : test_reset

    task automatic give_verdict();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // the full run needs about 2700 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    initial begin
        nrst = 1'b0;
        req_valid = 1'b0;
        req = '0;
        preset_en = 1'b0;
        preset_val = '0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        test_compare();
        test_skip();
        test_branch();
        test_b2b();
        test_reset();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
